// ### src/nvs_pkg.sv
// Operation
// - Ignore all reads and writes during store, recall or low supply.
// - Skip automatic or pin store when no write happened since last cycle.
// - Start acting on a software command within 500 us (code: a pin or power-loss store taken first delays it by the whole store).
// - Store and recall lock the interface until done; host waits.
// - Clean pin store: release pin driver, keep SRAM disabled while pin low.
// - Keep accepting a write for 25 ns after automatic or pin store starts (code: pin store only; low supply blocks grants in automatic grace).
package nvs_pkg;
  localparam int CLK_MHZ = 200;
  localparam int SOFT_SEQUENCE_LATENCY_US = 500;
  localparam int SOFT_LAT_CYC = SOFT_SEQUENCE_LATENCY_US * CLK_MHZ;
  localparam int WRITE_GRACE_TIME_NS = 25;
  localparam int GRACE_CYC = (WRITE_GRACE_TIME_NS * CLK_MHZ) / 1000;
  localparam int HW_STORE_PULSE_MIN_NS = 15;
  localparam int PULSE_CYC = (HW_STORE_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RECALL_TIME_MAX_US = 600;
  localparam int RECALL_CYC = RECALL_TIME_MAX_US * CLK_MHZ;
  localparam int STORE_TIME_MS = 8;
  localparam int STORE_CYC = STORE_TIME_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam logic [1:0] CMD_STORE = 2'h0;
  localparam logic [1:0] CMD_RECALL = 2'h1;
  localparam logic [1:0] CMD_AS_EN = 2'h2;
  localparam logic [1:0] CMD_AS_DIS = 2'h3;
  typedef enum logic [2:0] {
    NVS_IDLE = 3'h0,
    NVS_GRACE = 3'h1,
    NVS_STORE = 3'h2,
    NVS_RECALL = 3'h3,
    NVS_PIN_HOLD = 3'h4
  } nvs_state_e;
endpackage

// ### src/nvs_sync.sv
`timescale 1ns/100ps
`default_nettype none
module nvs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } nvs_sync_s;
  nvs_sync_s r_q, r_d;
  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end
  // Reset value is the idle-high level so a pulled-up pin reads released.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r_q <= '1;
    end else begin
      r_q <= r_d;
    end
  end
  assign q = r_q.s2;
endmodule
`default_nettype wire

// ### src/nvs_seq.sv
`timescale 1ns/100ps
`default_nettype none
module nvs_seq #(
  parameter int SOFT_LAT = nvs_pkg::SOFT_LAT_CYC,
  parameter int STORE_T = nvs_pkg::STORE_CYC,
  parameter int RECALL_T = nvs_pkg::RECALL_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic supply_low,
  input wire logic hw_store_busy_n_i,
  output logic hw_store_busy_n_o,
  output logic hw_store_busy_n_oe_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  input wire logic acc_req,
  input wire logic acc_write,
  output logic acc_grant,
  output logic sram_enable,
  output logic nv_store_pulse,
  output logic nv_recall_pulse,
  output logic busy,
  output logic power_loss_save_en,
  output logic dirty
);
  import nvs_pkg::*;
  typedef struct packed {
    nvs_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lat;
    logic [1:0] pend_cmd;
    logic pend;
    logic as_en;
    logic dirty;
    logic grant;
    logic sram_en;
    logic st_p;
    logic rc_p;
    logic busy;
    logic pin_oe_n;
    logic [1:0] low_cnt;
    logic sup_q;
    logic [2:0] drv_sh;
  } nvs_seq_s;
  nvs_seq_s r_q, r_d;
  logic pin_s, sup_s;
  nvs_sync #(.W(2)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({hw_store_busy_n_i, ~supply_low}),
    .q({pin_s, sup_s})
  );
  logic pin_req, loss_req, lock;
  always_comb begin
    r_d = r_q;
    r_d.st_p = 1'b0;
    r_d.rc_p = 1'b0;
    r_d.sup_q = sup_s;
    r_d.drv_sh = {r_q.drv_sh[1:0], !r_q.pin_oe_n};
    // Pin low must last the minimum pulse before it counts as a request.
    // Our own drive reaches pin_s through the synchroniser, so the low
    // count is held off while we drive and for a few cycles after.
    if (pin_s || !r_q.pin_oe_n || r_q.drv_sh != 3'h0) begin
      r_d.low_cnt = 2'h0;
    end else if (r_q.low_cnt != 2'h3) begin
      r_d.low_cnt = r_q.low_cnt + 2'h1;
    end
    pin_req = !pin_s && (32'(r_q.low_cnt) + 1 >= PULSE_CYC);
    loss_req = r_q.sup_q && !sup_s && r_q.as_en;
    lock = r_q.st != NVS_IDLE && r_q.st != NVS_GRACE;
    if (cmd_valid && !r_q.pend && r_q.st == NVS_IDLE) begin
      r_d.pend = 1'b1;
      r_d.pend_cmd = cmd_code;
      r_d.lat = '0;
    end else if (r_q.pend) begin
      r_d.lat = r_q.lat + 1'b1;
    end
    // Writes count only when granted; grace window still grants them unless supply is low.
    r_d.grant = acc_req && !lock && sup_s;
    if (acc_req && acc_write && r_d.grant) begin
      r_d.dirty = 1'b1;
    end
    case (r_q.st)
      NVS_IDLE: begin
        if (pin_req || loss_req) begin
          if (r_q.dirty) begin
            r_d.st = NVS_GRACE;
            r_d.cnt = '0;
          end else if (pin_req) begin
            // Nothing to save: release the driver and hold SRAM off.
            r_d.st = NVS_PIN_HOLD;
          end
        end else if (r_q.pend) begin
          // Commands act the cycle after they are taken, far inside 500 us, unless a pin or power-loss request wins that cycle.
          r_d.pend = 1'b0;
          r_d.cnt = '0;
          case (r_q.pend_cmd)
            CMD_STORE: r_d.st = NVS_STORE;
            CMD_RECALL: r_d.st = NVS_RECALL;
            CMD_AS_EN: r_d.as_en = 1'b1;
            CMD_AS_DIS: r_d.as_en = 1'b0;
            default: r_d.pend = 1'b0;
          endcase
        end
      end
      NVS_GRACE: begin
        r_d.cnt = r_q.cnt + 1'b1;
        if (32'(r_q.cnt) + 1 >= GRACE_CYC) begin
          r_d.st = NVS_STORE;
          r_d.cnt = '0;
        end
      end
      NVS_STORE, NVS_RECALL: begin
        r_d.cnt = r_q.cnt + 1'b1;
        if (32'(r_q.cnt) + 1 >= (r_q.st == NVS_STORE ? STORE_T : RECALL_T))
        begin
          r_d.st = NVS_IDLE;
          r_d.st_p = r_q.st == NVS_STORE;
          r_d.rc_p = r_q.st == NVS_RECALL;
          if (!(acc_req && acc_write && r_d.grant)) begin
            r_d.dirty = 1'b0;
          end
        end
      end
      NVS_PIN_HOLD: begin
        r_d.pin_oe_n = 1'b1;
        if (pin_s) begin
          r_d.st = NVS_IDLE;
        end
      end
      default: r_d.st = NVS_IDLE;
    endcase
    // The pin is driven low only while a store runs; recall leaves it free.
    r_d.pin_oe_n = r_d.st != NVS_STORE;
    r_d.busy = r_d.st != NVS_IDLE;
    r_d.sram_en = r_d.st == NVS_IDLE || r_d.st == NVS_GRACE;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r_q <= '0;
      r_q.st <= NVS_IDLE;
      r_q.as_en <= 1'b1;
      r_q.sram_en <= 1'b1;
      r_q.pin_oe_n <= 1'b1;
      r_q.low_cnt <= 2'h0;
    end else begin
      r_q <= r_d;
    end
  end
  assign hw_store_busy_n_o = 1'b0;
  assign hw_store_busy_n_oe_n = r_q.pin_oe_n;
  assign acc_grant = r_q.grant;
  assign sram_enable = r_q.sram_en;
  assign nv_store_pulse = r_q.st_p;
  assign nv_recall_pulse = r_q.rc_p;
  assign busy = r_q.busy;
  assign power_loss_save_en = r_q.as_en;
  assign dirty = r_q.dirty;

  a_lock_no_grant: assert property (@(posedge clk) disable iff (!rstn)
    (r_q.st == NVS_STORE || r_q.st == NVS_RECALL) |=> !acc_grant)
    else $error("access granted during cycle");
  a_skip_clean: assert property (@(posedge clk) disable iff (!rstn)
    (r_q.st == NVS_IDLE && !r_q.dirty && pin_req) |=>
    r_q.st != NVS_STORE && r_q.st != NVS_GRACE)
    else $error("store not skipped when clean");
  a_cmd_latency: assert property (@(posedge clk) disable iff (!rstn)
    (r_q.pend && r_q.st == NVS_IDLE && !pin_req && !loss_req) |=> !r_q.pend)
    else $error("command not acted on");
  a_store_busy: assert property (@(posedge clk) disable iff (!rstn)
    $rose(r_q.st == NVS_STORE) |-> busy [*4])
    else $error("busy dropped during store");
  a_pin_release: assert property (@(posedge clk) disable iff (!rstn)
    r_q.st == NVS_PIN_HOLD |-> hw_store_busy_n_oe_n && !sram_enable)
    else $error("pin driven or sram on in hold");
  a_grace_len: assert property (@(posedge clk) disable iff (!rstn)
    $rose(r_q.st == NVS_GRACE) |-> ##5 r_q.st == NVS_STORE)
    else $error("grace window length wrong");
  a_dirty_set: assert property (@(posedge clk) disable iff (!rstn)
    (r_d.grant && acc_req && acc_write) |=> dirty)
    else $error("dirty not set by write");
  a_dirty_clr: assert property (@(posedge clk) disable iff (!rstn)
    (nv_store_pulse && !$past(acc_write)) |-> !dirty)
    else $error("dirty not cleared after store");
  a_supply_lock: assert property (@(posedge clk) disable iff (!rstn)
    !sup_s |=> !acc_grant)
    else $error("access granted at low supply");
  a_grace_grant: assert property (@(posedge clk) disable iff (!rstn)
    (r_q.st == NVS_GRACE && acc_req && sup_s) |=> acc_grant)
    else $error("write refused in grace window");
  a_store_drive: assert property (@(posedge clk) disable iff (!rstn)
    r_q.st == NVS_STORE |-> !hw_store_busy_n_oe_n)
    else $error("pin not driven during store");
  a_recall_free: assert property (@(posedge clk) disable iff (!rstn)
    r_q.st == NVS_RECALL |-> hw_store_busy_n_oe_n)
    else $error("pin driven during recall");
  a_cycle_busy: assert property (@(posedge clk) disable iff (!rstn)
    r_q.st != NVS_IDLE |-> busy)
    else $error("busy low while cycle active");
  a_cmd_taken: assert property (@(posedge clk) disable iff (!rstn)
    (cmd_valid && !r_q.pend && r_q.st == NVS_IDLE) |=> r_q.pend)
    else $error("command not taken when idle");
  a_dirty_store: assert property (@(posedge clk) disable iff (!rstn)
    (pin_req && r_q.st == NVS_IDLE && r_q.dirty) |=> r_q.st == NVS_GRACE)
    else $error("dirty pin store not started");
  a_pulse_one: assert property (@(posedge clk) disable iff (!rstn)
    nv_store_pulse |=> !nv_store_pulse)
    else $error("store pulse longer than one cycle");
endmodule
`default_nettype wire

// ### sim/nvs_host.sv
`timescale 1ns/100ps
`default_nettype none
module nvs_host (
  input wire logic clk,
  input wire logic press,
  input wire logic dev_o,
  input wire logic dev_oe_n,
  output logic pin
);
  logic [1:0] hold_q = 2'h0;
  // A press is stretched by three cycles so the pin stays low over 15 ns.
  always_ff @(posedge clk) begin
    if (press)
      hold_q <= 2'h3;
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
  end
  // Access spacing is not modelled: this model has no regulator hazard,
  // so back to back accesses are legal here.
  // The pull-up wins unless the host or the device pulls the pin low.
  assign pin = !(press || hold_q != 2'h0) && (dev_oe_n || dev_o);
endmodule
`default_nettype wire

// ### sim/nv_store_recall_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module nv_store_recall_sequencer_tb_top;
  import nvs_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, sl = 1'b0, press = 1'b0, cv = 1'b0;
  logic rq = 1'b0, wr = 1'b0, sps = 1'b0, rps = 1'b0;
  logic [1:0] cc = 2'h0;
  logic pin, o, oe_n, gnt, sen, sp, rp, busy, asen, dirty;
  logic [3:0] rows [3] = '{4'ha, 4'h0, 4'hf};
  int bad_count = 0, cmp_count = 0, gb = 0, i;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (sp) sps <= 1'b1;
    if (rp) rps <= 1'b1;
    if (busy && gnt) gb++;
  end
  nvs_host nvs_host_i (.clk(clk), .press(press), .dev_o(o),
    .dev_oe_n(oe_n), .pin(pin));
  nvs_seq #(.STORE_T(50), .RECALL_T(40)) nvs_seq_i (.clk(clk), .rstn(rstn),
    .supply_low(sl), .hw_store_busy_n_i(pin), .hw_store_busy_n_o(o),
    .hw_store_busy_n_oe_n(oe_n), .cmd_valid(cv), .cmd_code(cc),
    .acc_req(rq), .acc_write(wr), .acc_grant(gnt), .sram_enable(sen),
    .nv_store_pulse(sp), .nv_recall_pulse(rp), .busy(busy),
    .power_loss_save_en(asen), .dirty(dirty));
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %b want %b", $time, got, exp);
    end
  endtask
  task automatic upto(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 400) begin
      bad_count++;
      $display("mismatch at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask
  task automatic cmd(input logic [1:0] c);
    @(posedge clk);
    cv <= 1'b1;
    cc <= c;
    sps <= 1'b0;
    rps <= 1'b0;
    @(posedge clk);
    cv <= 1'b0;
  endtask
  initial begin
    repeat (15) @(posedge clk);
    #1;
    chk(gnt | busy | dirty, 1'b0);
    chk(sen & oe_n & asen, 1'b1);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    $display("reset test done");
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      rq <= rows[i][3];
      wr <= rows[i][2];
      @(posedge clk);
      rq <= 1'b0;
      #1 chk(gnt, rows[i][1]);
      @(posedge clk);
      #1 chk(dirty, rows[i][0]);
      $display("row %0d done", i);
    end
    for (i = 0; i < 4; i++) begin
      cmd(i[1:0]);
      if (i < 2) begin
        upto(busy, 1'b1);
        chk(oe_n, i[0]);
        @(posedge clk);
        rq <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
        #1 chk(gnt, 1'b0);
        upto(busy, 1'b0);
        @(posedge clk);
        rq <= 1'b0;
        #1 chk(dirty, 1'b0);
        chk(sps, i == 0);
        chk(rps, i == 1);
      end else
        upto(asen, i == 2);
      $display("command %0d done", i);
    end
    @(posedge clk);
    press <= 1'b1;
    wr <= 1'b0;
    upto(busy, 1'b1);
    repeat (20) @(posedge clk);
    #1 chk(sen, 1'b0);
    chk(oe_n, 1'b1);
    @(posedge clk);
    press <= 1'b0;
    upto(sen, 1'b1);
    upto(busy, 1'b0);
    chk(sps, 1'b0);
    $display("clean pin store done");
    @(posedge clk);
    rq <= 1'b1;
    wr <= 1'b1;
    press <= 1'b1;
    gb = 0;
    @(posedge clk);
    press <= 1'b0;
    upto(oe_n, 1'b0);
    @(posedge clk);
    #1 chk(gnt, 1'b0);
    upto(busy, 1'b0);
    @(posedge clk);
    #1 chk(sps, 1'b1);
    chk(gb != 0, 1'b1);
    $display("dirty pin store done");
    @(posedge clk);
    sl <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(gnt, 1'b0);
    @(posedge clk);
    rq <= 1'b0;
    sl <= 1'b0;
    $display("supply low test done");
    print_verdict();
  end
endmodule
`default_nettype wire
